// ===== logic/second_output_pair_control.sv
// Register bank and gain sequencing for the second stereo output pair
`include "pair_b_regs.svh"
`default_nettype none
module second_output_pair_control #(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              left_zero_cross,
    input  wire logic              right_zero_cross,
    output logic [5:0]             left_b_volume_code,
    output logic [5:0]             right_b_volume_code,
    output logic                   left_b_mute,
    output logic                   right_b_mute,
    output logic                   right_invert_amp_en,
    output logic                   right_invert_amp_bypass,
    output logic                   pair_b_ground_feedback_en,
    output logic                   beep_path_en,
    output logic [2:0]             beep_level_code
);

    pair_b_pkg::state_t st;
    pair_b_pkg::state_t next_st;

    logic       wr_fire;
    logic       rd_fire;
    logic [9:0] wr_idx;
    logic [9:0] rd_idx;
    logic       wr_left;
    logic       wr_right;
    logic       vu_strobe;
    logic       inv_cfg;

    // Address and data are taken together; one write in flight at a time
    assign wr_fire = awvalid && wvalid && !st.bvalid;
    assign awready = wr_fire;
    assign wready  = wr_fire;
    assign arready = !st.rvalid;
    assign rd_fire = arvalid && !st.rvalid;
    assign wr_idx  = awaddr[11:2];
    assign rd_idx  = araddr[11:2];

    assign wr_left  = wr_fire && (wr_idx == `PB_IDX_LEFT_VOL);
    assign wr_right = wr_fire && (wr_idx == `PB_IDX_RIGHT_VOL);
    // Update bit may come from either volume register
    assign vu_strobe = (wr_left || wr_right) && wstrb[1]
                       && wdata[`PB_BIT_VU];

    always_comb begin
        next_st = st;
        inv_cfg = 1'b0;
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end

        if (wr_fire) begin
            next_st.bvalid = 1'b1;
            next_st.bresp  = `PB_RESP_OKAY;
            case (wr_idx)
                `PB_IDX_FEEDBACK: begin
                    if (wstrb[0]) begin
                        next_st.fb_en = wdata[`PB_BIT_FB_EN];
                    end
                end
                `PB_IDX_LEFT_VOL: begin
                    if (wstrb[0]) begin
                        // Held aside until the shared update
                        next_st.l_pend = wdata[`PB_VOL_MSB:`PB_VOL_LSB];
                    end
                    if (wstrb[1]) begin
                        next_st.l_mute = wdata[`PB_BIT_MUTE];
                        next_st.l_zc   = wdata[`PB_BIT_ZC];
                    end
                end
                `PB_IDX_RIGHT_VOL: begin
                    if (wstrb[0]) begin
                        next_st.r_pend = wdata[`PB_VOL_MSB:`PB_VOL_LSB];
                    end
                    if (wstrb[1]) begin
                        next_st.r_mute    = wdata[`PB_BIT_MUTE];
                        next_st.r_zc      = wdata[`PB_BIT_ZC];
                        next_st.r_inv_en  = wdata[`PB_BIT_INV_EN];
                        next_st.r_inv_byp = wdata[`PB_BIT_INV_BYPASS];
                    end
                end
                `PB_IDX_BEEP: begin
                    if (wstrb[0]) begin
                        next_st.beep_lvl = wdata[`PB_BEEP_MSB:`PB_BEEP_LSB];
                    end
                    if (wstrb[1]) begin
                        next_st.beep_en = wdata[`PB_BIT_BEEP_EN];
                    end
                end
                `PB_IDX_STATUS: begin
                    // Read-only; a write is accepted and dropped
                end
                default: begin
                    next_st.bresp = `PB_RESP_SLVERR;
                end
            endcase
        end

        // Both channels are armed by the same strobe; the strobe itself
        // is not stored, so it always reads back as zero
        if (vu_strobe) begin
            next_st.l_wait = 1'b1;
            next_st.r_wait = 1'b1;
        end

        // Transfer happens at once unless zero-cross gating is on; clearing
        // the gate while waiting releases the held code straight away
        if (next_st.l_wait
            && (!next_st.l_zc || (!vu_strobe && left_zero_cross))) begin
            next_st.l_gain = next_st.l_pend;
            next_st.l_wait = 1'b0;
        end
        if (next_st.r_wait
            && (!next_st.r_zc || (!vu_strobe && right_zero_cross))) begin
            next_st.r_gain = next_st.r_pend;
            next_st.r_wait = 1'b0;
        end

        // Only the paired setting counts as inverting; a mismatched pair
        // leaves beep off rather than guessing
        inv_cfg = next_st.r_inv_en && !next_st.r_inv_byp;
        next_st.beep_live = next_st.beep_en && inv_cfg;

        if (rd_fire) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `PB_RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            case (rd_idx)
                `PB_IDX_FEEDBACK: begin
                    next_st.rdata[`PB_BIT_FB_EN] = st.fb_en;
                end
                `PB_IDX_LEFT_VOL: begin
                    next_st.rdata[`PB_BIT_MUTE] = st.l_mute;
                    next_st.rdata[`PB_BIT_ZC]   = st.l_zc;
                    next_st.rdata[`PB_VOL_MSB:`PB_VOL_LSB] = st.l_pend;
                end
                `PB_IDX_RIGHT_VOL: begin
                    next_st.rdata[`PB_BIT_MUTE]       = st.r_mute;
                    next_st.rdata[`PB_BIT_ZC]         = st.r_zc;
                    next_st.rdata[`PB_BIT_INV_EN]     = st.r_inv_en;
                    next_st.rdata[`PB_BIT_INV_BYPASS] = st.r_inv_byp;
                    next_st.rdata[`PB_VOL_MSB:`PB_VOL_LSB] = st.r_pend;
                end
                `PB_IDX_BEEP: begin
                    next_st.rdata[`PB_BIT_BEEP_EN] = st.beep_en;
                    next_st.rdata[`PB_BEEP_MSB:`PB_BEEP_LSB] = st.beep_lvl;
                end
                `PB_IDX_STATUS: begin
                    next_st.rdata[5:0] = st.l_gain;
                    next_st.rdata[`PB_ST_RIGHT_LSB +: 6] = st.r_gain;
                    next_st.rdata[`PB_ST_L_WAIT]    = st.l_wait;
                    next_st.rdata[`PB_ST_R_WAIT]    = st.r_wait;
                    next_st.rdata[`PB_ST_INVERTING] =
                        st.r_inv_en && !st.r_inv_byp;
                end
                default: begin
                    next_st.rresp = `PB_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st           <= '0;
            st.l_pend    <= `PB_RST_VOL;
            st.l_gain    <= `PB_RST_VOL;
            st.r_pend    <= `PB_RST_VOL;
            st.r_gain    <= `PB_RST_VOL;
            st.r_inv_byp <= `PB_RST_INV_BYPASS;
            st.beep_lvl  <= `PB_RST_BEEP_LVL;
        end else begin
            st <= next_st;
        end
    end

    assign bvalid  = st.bvalid;
    assign bresp   = st.bresp;
    assign rvalid  = st.rvalid;
    assign rdata   = st.rdata;
    assign rresp   = st.rresp;

    assign left_b_volume_code        = st.l_gain;
    assign right_b_volume_code       = st.r_gain;
    // Mute is independent of the polarity selection
    assign left_b_mute               = st.l_mute;
    assign right_b_mute              = st.r_mute;
    assign right_invert_amp_en       = st.r_inv_en;
    assign right_invert_amp_bypass   = st.r_inv_byp;
    assign pair_b_ground_feedback_en = st.fb_en;
    assign beep_path_en              = st.beep_live;
    assign beep_level_code           = st.beep_lvl;

    chk_vol_held_pending: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_left && !vu_strobe && !st.l_wait)
            |=> $stable(left_b_volume_code))
        else $error("left gain changed without update strobe");

    chk_vol_both_apply: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (vu_strobe && !st.l_zc && !st.r_zc && !wdata[`PB_BIT_ZC])
            |=> (left_b_volume_code == st.l_pend)
                && (right_b_volume_code == st.r_pend))
        else $error("update strobe did not apply both pending codes");

    // A left-volume write that sets the gate bit along with the update tells the left channel to wait
    chk_zc_defers_gain: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_left && vu_strobe && wdata[`PB_BIT_ZC])
            |=> st.l_wait && $stable(left_b_volume_code))
        else $error("zero-cross gated update applied early");

    chk_zc_release: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (st.l_wait && left_zero_cross && !wr_fire)
            |=> !st.l_wait && (left_b_volume_code == $past(st.l_pend)))
        else $error("zero cross did not release left gain");

    chk_right_zc_release: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (st.r_wait && right_zero_cross && !wr_fire)
            |=> !st.r_wait && (right_b_volume_code == $past(st.r_pend)))
        else $error("zero cross did not release right gain");

    chk_mute_follows: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_right && wstrb[1])
            |=> right_b_mute == $past(wdata[`PB_BIT_MUTE]))
        else $error("right mute does not follow write");

    chk_inv_bits_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_right && wstrb[1])
            |=> (right_invert_amp_en == $past(wdata[`PB_BIT_INV_EN]))
                && (right_invert_amp_bypass
                    == $past(wdata[`PB_BIT_INV_BYPASS])))
        else $error("polarity bits do not follow write");

    chk_beep_inverting: assert property (
        @(posedge aclk) disable iff (!aresetn)
        beep_path_en |-> right_invert_amp_en && !right_invert_amp_bypass)
        else $error("beep enabled outside inverting configuration");

    chk_beep_when_paired: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (st.beep_en && right_invert_amp_en && !right_invert_amp_bypass)
            |-> beep_path_en)
        else $error("beep blocked in inverting configuration");

    chk_beep_level: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_idx == `PB_IDX_BEEP && wstrb[0])
            |=> beep_level_code == $past(wdata[`PB_BEEP_MSB:`PB_BEEP_LSB]))
        else $error("beep level does not follow write");

    chk_feedback_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_idx == `PB_IDX_FEEDBACK && wstrb[0])
            |=> pair_b_ground_feedback_en == $past(wdata[`PB_BIT_FB_EN]))
        else $error("feedback enable does not follow write");

    chk_write_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire |=> bvalid)
        else $error("write not answered");

    chk_read_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_fire |=> rvalid)
        else $error("read not answered");

endmodule // second_output_pair_control
`default_nettype wire

// ===== logic/pair_b_regs.svh
// Register indices, field positions, reset values for the output pair block
`ifndef PAIR_B_REGS_SVH
`define PAIR_B_REGS_SVH

// Register indices; byte address is four times the index
`define PB_IDX_FEEDBACK     10'h04c
`define PB_IDX_LEFT_VOL     10'h06a
`define PB_IDX_RIGHT_VOL    10'h06b
`define PB_IDX_BEEP         10'h06f
`define PB_IDX_STATUS       10'h070

// Field positions
`define PB_BIT_FB_EN        2
`define PB_BIT_MUTE         14
`define PB_BIT_ZC           13
`define PB_BIT_INV_EN       10
`define PB_BIT_INV_BYPASS   9
`define PB_BIT_VU           8
`define PB_VOL_MSB          7
`define PB_VOL_LSB          2
`define PB_BIT_BEEP_EN      15
`define PB_BEEP_MSB         7
`define PB_BEEP_LSB         5
`define PB_ST_RIGHT_LSB     8
`define PB_ST_L_WAIT        16
`define PB_ST_R_WAIT        17
`define PB_ST_INVERTING     18

// Reset values
`define PB_RST_VOL          6'h39
`define PB_RST_INV_BYPASS   1'h1
`define PB_RST_BEEP_LVL     3'h0

// Bus answers
`define PB_RESP_OKAY        2'h0
`define PB_RESP_SLVERR      2'h2

`endif

// ===== logic/pair_b_pkg.sv
// Types shared by the second output pair control block
`default_nettype none
package pair_b_pkg;

    typedef struct packed {
        logic        fb_en;
        logic        l_mute;
        logic        l_zc;
        logic [5:0]  l_pend;
        logic [5:0]  l_gain;
        logic        l_wait;
        logic        r_mute;
        logic        r_zc;
        logic        r_inv_en;
        logic        r_inv_byp;
        logic [5:0]  r_pend;
        logic [5:0]  r_gain;
        logic        r_wait;
        logic        beep_en;
        logic [2:0]  beep_lvl;
        logic        beep_live;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;

endpackage
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the second output pair control block
`include "pair_b_regs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk             = 1'b0;
    logic        aresetn          = 1'b0;
    logic [11:0] awaddr           = 12'h000;
    logic        awvalid          = 1'b0;
    logic        awready;
    logic [31:0] wdata            = 32'h00000000;
    logic [3:0]  wstrb            = 4'hf;
    logic        wvalid           = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready           = 1'b1;
    logic [11:0] araddr           = 12'h000;
    logic        arvalid          = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready           = 1'b1;
    logic        left_zero_cross  = 1'b0;
    logic        right_zero_cross = 1'b0;
    logic [5:0]  lvol;
    logic [5:0]  rvol;
    logic        lmute;
    logic        rmute;
    logic        inv_en;
    logic        byp;
    logic        fb_en;
    logic        beep_en;
    logic [2:0]  beep_lvl;
    int          bad_count        = 0;
    int          samples_checked  = 0;

    always #5 aclk = ~aclk;

    second_output_pair_control u_second_output_pair_control (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .left_zero_cross(left_zero_cross),
        .right_zero_cross(right_zero_cross),
        .left_b_volume_code(lvol), .right_b_volume_code(rvol),
        .left_b_mute(lmute), .right_b_mute(rmute),
        .right_invert_amp_en(inv_en), .right_invert_amp_bypass(byp),
        .pair_b_ground_feedback_en(fb_en),
        .beep_path_en(beep_en), .beep_level_code(beep_lvl)
    );

    task automatic end_sim();
        $display("Compared %0d, mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic limit(input logic ok);
        if (ok !== 1'h1) begin
            bad_count++;
            $display("Error at %0t: bus answer missing", $time);
            end_sim();
        end
    endtask

    // Ready and valid are looked at on the falling edge, where they are
    // settled, and the handshake lands on the rising edge after it
    task automatic wr(input logic [9:0] idx, input logic [15:0] d,
                      output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(negedge aclk);
            n++;
        end while (!(awready === 1'b1 && wready === 1'b1) && n < 100);
        limit(awready === 1'h1 && wready === 1'h1);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        limit(bvalid === 1'h1);
        resp = bresp;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [9:0] idx, output logic [31:0] d,
                      output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 100);
        limit(arready === 1'h1);
        @(posedge aclk);
        arvalid <= 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        limit(rvalid === 1'h1);
        d    = rdata;
        resp = rresp;
        @(posedge aclk);
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`PB_IDX_LEFT_VOL, d, r);
        check(d, 32'h000000e4);
        rd(`PB_IDX_RIGHT_VOL, d, r);
        check(d, 32'h000002e4);
        rd(`PB_IDX_FEEDBACK, d, r);
        check(d, 32'h00000000);
        rd(`PB_IDX_BEEP, d, r);
        check(d, 32'h00000000);
        check({20'h0, lvol, rvol}, 32'h00000e79);
        check({28'h0, inv_en, byp, fb_en, beep_en}, 32'h4);
        // Codes written without the update bit must stay pending
        wr(`PB_IDX_LEFT_VOL, 16'h0000, r);
        wr(`PB_IDX_RIGHT_VOL, 16'h42fc, r);
        check({20'h0, lvol, rvol}, 32'h00000e79);
        check({30'h0, lmute, rmute}, 32'h1);
        wr(`PB_IDX_LEFT_VOL, 16'h0100, r);
        check({30'h0, r}, 32'h0);
        check({20'h0, lvol, rvol}, 32'h0000003f);
        rd(`PB_IDX_LEFT_VOL, d, r);
        check(d, 32'h00000000);
        // Zero-cross deferral holds the new left code until the crossing
        wr(`PB_IDX_LEFT_VOL, 16'h2140, r);
        rd(`PB_IDX_STATUS, d, r);
        check(d, 32'h00013f00);
        repeat (3) @(posedge aclk);
        check({26'h0, lvol}, 32'h0);
        left_zero_cross <= 1'b1;
        repeat (2) @(posedge aclk);
        left_zero_cross <= 1'b0;
        check({26'h0, lvol}, 32'h10);
        // Inverting pair lets the beep through, non-inverting blocks it
        wr(`PB_IDX_RIGHT_VOL, 16'h44fc, r);
        wr(`PB_IDX_BEEP, 16'h80e0, r);
        repeat (2) @(posedge aclk);
        check({25'h0, inv_en, byp, beep_en, rmute, beep_lvl}, 32'h5f);
        wr(`PB_IDX_RIGHT_VOL, 16'h42fc, r);
        repeat (2) @(posedge aclk);
        check({28'h0, inv_en, byp, beep_en, rmute}, 32'h5);
        for (int i = 0; i < 8; i++) begin
            wr(`PB_IDX_BEEP, {1'b1, 7'h00, 3'(i), 5'h00}, r);
            rd(`PB_IDX_BEEP, d, r);
            check(d, {16'h0, 1'b1, 7'h00, 3'(i), 5'h00});
            check({29'h0, beep_lvl}, 32'(i));
        end
        wr(`PB_IDX_FEEDBACK, 16'h0004, r);
        repeat (2) @(posedge aclk);
        check({31'h0, fb_en}, 32'h1);
        rd(`PB_IDX_FEEDBACK, d, r);
        check(d, 32'h00000004);
        // Both channels gated: only the right crossing releases its code
        wr(`PB_IDX_RIGHT_VOL, 16'h2314, r);
        rd(`PB_IDX_STATUS, d, r);
        check(d, 32'h00033f10);
        right_zero_cross <= 1'h1;
        repeat (2) @(posedge aclk);
        right_zero_cross <= 1'h0;
        check({20'h0, lvol, rvol}, 32'h00000405);
        rd(`PB_IDX_STATUS, d, r);
        check(d, 32'h00010510);
        // Dropping the gate while waiting applies the pending code at once
        wr(`PB_IDX_LEFT_VOL, 16'h0000, r);
        check({26'h0, lvol}, 32'h0);
        // Unmapped place answers with an error and reads as zero
        wr(10'h3ff, 16'hffff, r);
        check({30'h0, r}, {30'h0, `PB_RESP_SLVERR});
        rd(10'h3ff, d, r);
        check(d, 32'h00000000);
        check({30'h0, r}, {30'h0, `PB_RESP_SLVERR});
        // Reset in mid-run brings every field back to its default
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`PB_IDX_RIGHT_VOL, d, r);
        check(d, 32'h000002e4);
        check({20'h0, lvol, rvol}, 32'h00000e79);
        check({28'h0, inv_en, byp, fb_en, beep_en}, 32'h4);
        end_sim();
    end
endmodule // tb
`default_nettype wire
